//--- rtl/bit_and_transfer_exec_pkg.sv
package bit_and_transfer_exec_pkg;

  // ***********************************************************
  // Register map (byte addresses on APB)
  // ***********************************************************
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_REG_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_REG_DATA = 8'h0c;
  localparam logic [7:0] ADDR_FLAG_WORD = 8'h10;
  localparam logic [7:0] ADDR_STACK_PTR = 8'h14;

  // ***********************************************************
  // Command word fields
  // ***********************************************************
  localparam int CMD_OP_LSB = 27;
  localparam int CMD_REG_LSB = 22;
  localparam int CMD_BIT_LSB = 19;
  localparam int CMD_PORT_LSB = 13;
  localparam int CMD_ADDR_LSB = 0;

  // Register window write fields
  localparam int WIN_INDEX_LSB = 0;
  localparam int WIN_VALUE_LSB = 8;
  localparam int WIN_WRITE_BIT = 16;

  // Status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FLAGS_LSB = 8;
  localparam int STAT_SP_LSB = 16;

  // ***********************************************************
  // Flag word bit positions
  // ***********************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ***********************************************************
  // Reset values and register indices
  // ***********************************************************
  localparam logic [7:0] FLAG_WORD_RESET = 8'h00;
  localparam logic [15:0] STACK_PTR_RESET = 16'h0000;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_ONE = 5'h01;
  localparam logic [4:0] REG_Z_LOW = 5'h1e;
  localparam logic [4:0] REG_Z_HIGH = 5'h1f;

  // ***********************************************************
  // Cycle counts per instruction
  // ***********************************************************
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_STORE = 2'd2;
  localparam logic [1:0] CYC_STACK = 2'd2;
  localparam logic [1:0] CYC_IO_BIT = 2'd2;
  localparam logic [1:0] CYC_CODE_LOAD = 2'd3;

  // ***********************************************************
  // Operations, in command code order
  // ***********************************************************
  typedef enum logic [4:0] {
    op_nop,
    op_offset_store,
    op_direct_store,
    op_code_space_load_r0,
    op_code_space_load,
    op_code_space_load_inc,
    op_code_space_write,
    op_port_in,
    op_port_out,
    op_push,
    op_pop,
    op_io_bit_force_high,
    op_io_bit_force_low,
    op_logical_shift_up,
    op_logical_shift_down,
    op_rotate_up_via_carry,
    op_rotate_down_via_carry,
    op_signed_shift_down,
    op_nibble_swap,
    op_flag_set,
    op_flag_clear,
    op_bit_to_transfer_flag,
    op_transfer_flag_to_bit,
    op_sleep,
    op_watchdog_restart
  } op_t;

  typedef enum {
    st_idle,
    st_exec,
    st_code_write
  } exec_state_t;

endpackage : bit_and_transfer_exec_pkg

//--- rtl/bit_and_transfer_exec.sv
// The register addresses and the APB register port were decided locally.
module bit_and_transfer_exec
  import bit_and_transfer_exec_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Data memory
  output logic [ADDR_W-1:0] dmem_addr_o,
  output logic dmem_we_o,
  output logic dmem_re_o,
  output logic [7:0] dmem_wdata_o,
  input wire logic [7:0] dmem_rdata_i,
  // Program memory
  output logic [ADDR_W-1:0] pmem_addr_o,
  output logic pmem_re_o,
  input wire logic [7:0] pmem_rdata_i,
  output logic pmem_we_o,
  output logic [15:0] pmem_wdata_o,
  input wire logic pmem_done_i,
  // I/O register space
  output logic [5:0] io_addr_o,
  output logic io_we_o,
  output logic io_re_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  // Control strobes
  output logic sleep_req_o,
  output logic wdt_restart_o
);

  // Elaboration check on the pointer width
  if (ADDR_W != 16) begin : g_addr_w_check
    $error("ADDR_W must be 16 to match the pointer width");
  end

  // ***********************************************************
  // State
  // ***********************************************************
  logic [7:0] gpr_reg [32];
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic flag_we;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic sp_we;
  exec_state_t state_reg;
  logic [31:0] cmd_reg;
  logic [1:0] cyc_reg;
  logic [7:0] latch_reg;
  logic [4:0] win_index_reg;
  // Command fields
  op_t op;
  logic [4:0] reg_sel;
  logic [2:0] bit_sel;
  logic [5:0] port_sel;
  logic [15:0] direct_addr;
  logic [15:0] z_ptr;
  logic [7:0] src;
  assign op = op_t'(cmd_reg[CMD_OP_LSB +: 5]);
  assign reg_sel = cmd_reg[CMD_REG_LSB +: 5];
  assign bit_sel = cmd_reg[CMD_BIT_LSB +: 3];
  assign port_sel = cmd_reg[CMD_PORT_LSB +: 6];
  assign direct_addr = cmd_reg[CMD_ADDR_LSB +: 16];
  assign z_ptr = {gpr_reg[REG_Z_HIGH], gpr_reg[REG_Z_LOW]};
  assign src = gpr_reg[reg_sel];

  // ***********************************************************
  // APB decode
  // ***********************************************************
  logic apb_xfer;
  logic apb_wr;
  logic busy;
  logic mapped;
  logic wr_refused;
  assign busy = (state_reg != st_idle);
  assign apb_xfer = psel_i && penable_i;
  assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= ADDR_STACK_PTR);
  // Writes that would race the running instruction are refused
  assign wr_refused = busy && (paddr_i != ADDR_STATUS) && (paddr_i != ADDR_REG_DATA);
  assign apb_wr = apb_xfer && pwrite_i && mapped && !wr_refused;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_xfer && (!mapped || (pwrite_i && wr_refused));
  // Read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    unique case (paddr_i)
      ADDR_COMMAND: prdata_o = cmd_reg;
      ADDR_STATUS: begin
        prdata_o[STAT_BUSY_BIT] = busy;
        prdata_o[STAT_FLAGS_LSB +: 8] = flag_reg;
        prdata_o[STAT_SP_LSB +: 16] = sp_reg;
      end
      ADDR_REG_WINDOW: prdata_o[WIN_INDEX_LSB +: 5] = win_index_reg;
      ADDR_REG_DATA: prdata_o[7:0] = gpr_reg[win_index_reg];
      ADDR_FLAG_WORD: prdata_o[7:0] = flag_reg;
      ADDR_STACK_PTR: prdata_o[15:0] = sp_reg;
      default: prdata_o = 32'h0000_0000;
    endcase
  end

  // ***********************************************************
  // Execution datapath
  // ***********************************************************
  logic last;
  logic [1:0] cyc_total;
  logic rf_we;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic z_inc;
  logic [7:0] res;
  logic [7:0] bit_mask;
  assign bit_mask = 8'h01 << bit_sel;
  // Cycle count of the current operation
  always_comb begin
    unique case (op)
      op_offset_store, op_direct_store: cyc_total = CYC_STORE;
      op_push, op_pop: cyc_total = CYC_STACK;
      op_io_bit_force_high, op_io_bit_force_low: cyc_total = CYC_IO_BIT;
      op_code_space_load_r0, op_code_space_load, op_code_space_load_inc:
        cyc_total = CYC_CODE_LOAD;
      default: cyc_total = CYC_ONE;
    endcase
  end
  assign last = (state_reg == st_exec) && (cyc_reg == cyc_total - 2'd1);
  // Per-cycle actions, register write-back and flag update
  always_comb begin
    rf_we = 1'b0;
    rf_waddr = reg_sel;
    rf_wdata = 8'h00;
    z_inc = 1'b0;
    flag_next = flag_reg;
    flag_we = 1'b0;
    sp_next = sp_reg;
    sp_we = 1'b0;
    res = 8'h00;
    dmem_addr_o = '0;
    dmem_we_o = 1'b0;
    dmem_re_o = 1'b0;
    dmem_wdata_o = src;
    pmem_addr_o = z_ptr;
    pmem_re_o = 1'b0;
    pmem_we_o = 1'b0;
    pmem_wdata_o = {gpr_reg[REG_ONE], gpr_reg[REG_ZERO]};
    io_addr_o = port_sel;
    io_we_o = 1'b0;
    io_re_o = 1'b0;
    io_wdata_o = src;
    sleep_req_o = 1'b0;
    wdt_restart_o = 1'b0;
    if (state_reg == st_code_write) begin
      pmem_we_o = 1'b1;
    end else if (state_reg == st_exec) begin
      unique case (op)
        op_offset_store: begin
          dmem_addr_o = z_ptr + {10'h000, port_sel};
          dmem_we_o = (cyc_reg == 2'd0);
        end
        op_direct_store: begin
          dmem_addr_o = direct_addr;
          dmem_we_o = (cyc_reg == 2'd0);
        end
        op_code_space_load_r0, op_code_space_load, op_code_space_load_inc: begin
          pmem_re_o = (cyc_reg == 2'd1);
          rf_we = last;
          rf_waddr = (op == op_code_space_load_r0) ? REG_ZERO : reg_sel;
          rf_wdata = latch_reg;
          z_inc = last && (op == op_code_space_load_inc);
        end
        op_push: begin
          dmem_addr_o = sp_reg;
          dmem_we_o = (cyc_reg == 2'd0);
          sp_next = sp_reg - 16'h0001;
          sp_we = (cyc_reg == 2'd0);
        end
        op_pop: begin
          sp_next = sp_reg + 16'h0001;
          sp_we = (cyc_reg == 2'd0);
          dmem_addr_o = sp_reg;
          dmem_re_o = last;
          rf_we = last;
          rf_wdata = dmem_rdata_i;
        end
        op_io_bit_force_high: begin
          // read, then write with bit set
          io_re_o = (cyc_reg == 2'd0);
          io_we_o = last;
          io_wdata_o = latch_reg | bit_mask;
        end
        op_io_bit_force_low: begin
          // read, then write with bit cleared
          io_re_o = (cyc_reg == 2'd0);
          io_we_o = last;
          io_wdata_o = latch_reg & ~bit_mask;
        end
        op_logical_shift_up, op_rotate_up_via_carry: begin
          // shift up, carry from bit 7
          res = {src[6:0], (op == op_rotate_up_via_carry) ? flag_reg[FLAG_C] : 1'b0};
          flag_next[FLAG_C] = src[7];
          flag_next[FLAG_N] = res[7];
          flag_next[FLAG_Z] = (res == 8'h00);
          flag_next[FLAG_V] = res[7] ^ src[7];
          flag_we = 1'b1;
          rf_we = 1'b1;
          rf_wdata = res;
        end
        op_logical_shift_down, op_rotate_down_via_carry, op_signed_shift_down: begin
          // shift down, carry from bit 0
          res[6:0] = src[7:1];
          res[7] = (op == op_rotate_down_via_carry) ? flag_reg[FLAG_C] :
                   (op == op_signed_shift_down) ? src[7] : 1'b0;
          flag_next[FLAG_C] = src[0];
          flag_next[FLAG_N] = res[7];
          flag_next[FLAG_Z] = (res == 8'h00);
          flag_next[FLAG_V] = res[7] ^ src[0];
          flag_we = 1'b1;
          rf_we = 1'b1;
          rf_wdata = res;
        end
        op_nibble_swap: begin
          rf_we = 1'b1;
          rf_wdata = {src[3:0], src[7:4]};
        end
        op_port_in: begin
          io_re_o = 1'b1;
          rf_we = 1'b1;
          rf_wdata = io_rdata_i;
        end
        op_port_out: begin
          io_we_o = 1'b1;
        end
        op_flag_set: begin
          flag_next[bit_sel] = 1'b1;
          flag_we = 1'b1;
        end
        op_flag_clear: begin
          flag_next[bit_sel] = 1'b0;
          flag_we = 1'b1;
        end
        op_bit_to_transfer_flag: begin
          flag_next[FLAG_T] = src[bit_sel];
          flag_we = 1'b1;
        end
        op_transfer_flag_to_bit: begin
          rf_we = 1'b1;
          rf_wdata = flag_reg[FLAG_T] ? (src | bit_mask) : (src & ~bit_mask);
        end
        op_sleep: begin
          sleep_req_o = 1'b1;
        end
        op_watchdog_restart: begin
          wdt_restart_o = 1'b1;
        end
        default: rf_we = 1'b0;
      endcase
    end
  end

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  // Command start, cycle count and completion
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= st_idle;
      cmd_reg <= 32'h0000_0000;
      cyc_reg <= 2'd0;
    end else begin
      unique case (state_reg)
        st_idle: begin
          if (apb_wr && (paddr_i == ADDR_COMMAND)) begin
            cmd_reg <= pwdata_i;
            cyc_reg <= 2'd0;
            state_reg <= (op_t'(pwdata_i[CMD_OP_LSB +: 5]) == op_code_space_write) ?
                         st_code_write : st_exec;
          end
        end
        st_exec: begin
          cyc_reg <= cyc_reg + 2'd1;
          if (last) begin
            state_reg <= st_idle;
          end
        end
        st_code_write: begin
          if (pmem_done_i) begin
            state_reg <= st_idle;
          end
        end
      endcase
    end
  end
  // Read data held for read-modify-write and code loads
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_reg <= 8'h00;
    end else if (io_re_o) begin
      latch_reg <= io_rdata_i;
    end else if (pmem_re_o) begin
      latch_reg <= pmem_rdata_i;
    end
  end

  // ***********************************************************
  // Register file, flags and stack pointer
  // ***********************************************************
  // General registers, with Z increment applied last
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        gpr_reg[i] <= 8'h00;
      end
    end else if (apb_wr && (paddr_i == ADDR_REG_WINDOW) && pwdata_i[WIN_WRITE_BIT]) begin
      gpr_reg[pwdata_i[WIN_INDEX_LSB +: 5]] <= pwdata_i[WIN_VALUE_LSB +: 8];
    end else begin
      if (rf_we) begin
        gpr_reg[rf_waddr] <= rf_wdata;
      end
      if (z_inc) begin
        {gpr_reg[REG_Z_HIGH], gpr_reg[REG_Z_LOW]} <= z_ptr + 16'h0001;
      end
    end
  end
  // Register window index
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      win_index_reg <= 5'h00;
    end else if (apb_wr && (paddr_i == ADDR_REG_WINDOW)) begin
      win_index_reg <= pwdata_i[WIN_INDEX_LSB +: 5];
    end
  end
  // Flag word
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_reg <= FLAG_WORD_RESET;
    end else if (apb_wr && (paddr_i == ADDR_FLAG_WORD)) begin
      flag_reg <= pwdata_i[7:0];
    end else if (flag_we) begin
      flag_reg <= flag_next;
    end
  end
  // Stack pointer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_reg <= STACK_PTR_RESET;
    end else if (apb_wr && (paddr_i == ADDR_STACK_PTR)) begin
      sp_reg <= pwdata_i[15:0];
    end else if (sp_we) begin
      sp_reg <= sp_next;
    end
  end
endmodule : bit_and_transfer_exec

//--- dv/bit_and_transfer_exec_checker.sv
module bit_and_transfer_exec_checker #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic dmem_we_o,
  input wire logic dmem_re_o,
  input wire logic [ADDR_W-1:0] pmem_addr_o,
  input wire logic pmem_re_o,
  input wire logic pmem_we_o,
  input wire logic pmem_done_i,
  input wire logic [5:0] io_addr_o,
  input wire logic io_we_o,
  input wire logic io_re_o,
  input wire logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  input wire logic sleep_req_o,
  input wire logic wdt_restart_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************************
  // Strobe timing checks
  // ***********************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // I/O byte fetched, then written back one cycle later
  sequence io_fetch_s;
    io_re_o ##1 io_we_o;
  endsequence
  sequence io_one_bit_s;
    io_addr_o == $past(io_addr_o) && $countones(io_wdata_o ^ $past(io_rdata_i)) <= 1;
  endsequence

  io_bit_a: assert property (io_fetch_s |-> io_one_bit_s)
    else $error("I/O bit operation changed more than one bit");
  store_pulse_a: assert property (dmem_we_o |=> !dmem_we_o)
    else $error("Data store strobe held too long");
  pop_read_a: assert property (dmem_re_o |-> !dmem_we_o ##1 !dmem_re_o)
    else $error("Stack read strobe malformed");
  code_read_a: assert property (pmem_re_o |-> !$past(pmem_re_o) ##1 !pmem_re_o)
    else $error("Code read strobe malformed");
  write_hold_a: assert property (pmem_we_o && !pmem_done_i |=> pmem_we_o && $stable(pmem_addr_o))
    else $error("Code write dropped before done");
  write_end_a: assert property (pmem_we_o && pmem_done_i |=> !pmem_we_o)
    else $error("Code write held after done");
  sleep_pulse_a: assert property (sleep_req_o |-> !wdt_restart_o ##1 !sleep_req_o)
    else $error("Sleep request not a lone pulse");
  wdt_pulse_a: assert property (wdt_restart_o |-> !dmem_we_o && !io_we_o ##1 !wdt_restart_o)
    else $error("Watchdog restart not a lone pulse");
endmodule : bit_and_transfer_exec_checker

bind bit_and_transfer_exec bit_and_transfer_exec_checker #(.ADDR_W(ADDR_W)) u_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .dmem_we_o(dmem_we_o), .dmem_re_o(dmem_re_o),
  .pmem_addr_o(pmem_addr_o), .pmem_re_o(pmem_re_o), .pmem_we_o(pmem_we_o),
  .pmem_done_i(pmem_done_i), .io_addr_o(io_addr_o), .io_we_o(io_we_o), .io_re_o(io_re_o),
  .io_wdata_o(io_wdata_o), .io_rdata_i(io_rdata_i), .sleep_req_o(sleep_req_o),
  .wdt_restart_o(wdt_restart_o));

//--- dv/mem_io_model.sv
module mem_io_model #(
  parameter int ADDR_W = 16,
  parameter int DONE_DLY = 6
) (
  input wire logic core_clk_i,
  input wire logic [ADDR_W-1:0] dmem_addr_i,
  input wire logic dmem_we_i,
  input wire logic dmem_re_i,
  input wire logic [7:0] dmem_wdata_i,
  output logic [7:0] dmem_rdata_o,
  input wire logic [ADDR_W-1:0] pmem_addr_i,
  input wire logic pmem_re_i,
  input wire logic pmem_we_i,
  input wire logic [15:0] pmem_wdata_i,
  output logic [7:0] pmem_rdata_o,
  output logic pmem_done_o,
  input wire logic [5:0] io_addr_i,
  input wire logic io_we_i,
  input wire logic io_re_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dmem [256];
  logic [7:0] io [64];
  logic [7:0] d_last = 8'h00;
  logic [7:0] p_last = 8'h00;
  logic [7:0] i_last = 8'h00;
  logic [3:0] wait_cnt = 4'h0;
  logic [15:0] pw_word = 16'h0000;
  logic [ADDR_W-1:0] pw_addr = '0;

  // Clear memories, one preset I/O byte
  initial begin
    for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
    for (int i = 0; i < 64; i++) io[i] = 8'h00;
    io[3] = 8'h81;
  end

  // Same-cycle reads; an idle line shows the inverse of its last value
  assign dmem_rdata_o = dmem_re_i ? dmem[dmem_addr_i[7:0]] : ~d_last;
  assign pmem_rdata_o = pmem_re_i ? (pmem_addr_i[7:0] ^ 8'h3c) : ~p_last;
  assign io_rdata_o = io_re_i ? io[io_addr_i] : ~i_last;
  assign pmem_done_o = pmem_we_i && (wait_cnt == DONE_DLY[3:0]);

  // Writes, last values and code write capture
  always @(posedge core_clk_i) begin
    d_last <= dmem_rdata_o;
    p_last <= pmem_rdata_o;
    i_last <= io_rdata_o;
    if (dmem_we_i) dmem[dmem_addr_i[7:0]] <= dmem_wdata_i;
    if (io_we_i) io[io_addr_i] <= io_wdata_i;
    wait_cnt <= pmem_we_i ? wait_cnt + 4'h1 : 4'h0;
    if (pmem_done_o) pw_word <= pmem_wdata_i;
    if (pmem_done_o) pw_addr <= pmem_addr_i;
  end
endmodule : mem_io_model

//--- dv/tb_bit_and_transfer_exec.sv
module tb_bit_and_transfer_exec import bit_and_transfer_exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, v;
  logic pready_o, pslverr_o, e, dmem_we_o, dmem_re_o, pmem_re_o, pmem_we_o, pmem_done_i;
  logic [15:0] dmem_addr_o, pmem_addr_o, pmem_wdata_o, ex;
  logic [7:0] dmem_wdata_o, dmem_rdata_i, pmem_rdata_i, io_wdata_o, io_rdata_i, sv, fv;
  logic [5:0] io_addr_o;
  logic io_we_o, io_re_o, sleep_req_o, wdt_restart_o;
  int bad_count = 0;
  int checks = 0;
  int sleep_cnt = 0;
  int wdt_cnt = 0;
  op_t sh_ops [5] = '{op_logical_shift_up, op_logical_shift_down, op_rotate_up_via_carry,
                      op_rotate_down_via_carry, op_signed_shift_down};

  bit_and_transfer_exec #(.ADDR_W(16)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .dmem_addr_o(dmem_addr_o), .dmem_we_o(dmem_we_o), .dmem_re_o(dmem_re_o),
    .dmem_wdata_o(dmem_wdata_o), .dmem_rdata_i(dmem_rdata_i), .pmem_addr_o(pmem_addr_o),
    .pmem_re_o(pmem_re_o), .pmem_rdata_i(pmem_rdata_i), .pmem_we_o(pmem_we_o),
    .pmem_wdata_o(pmem_wdata_o), .pmem_done_i(pmem_done_i), .io_addr_o(io_addr_o),
    .io_we_o(io_we_o), .io_re_o(io_re_o), .io_wdata_o(io_wdata_o), .io_rdata_i(io_rdata_i),
    .sleep_req_o(sleep_req_o), .wdt_restart_o(wdt_restart_o));
  mem_io_model #(.ADDR_W(16), .DONE_DLY(6)) mdl (.core_clk_i(core_clk_i),
    .dmem_addr_i(dmem_addr_o), .dmem_we_i(dmem_we_o), .dmem_re_i(dmem_re_o),
    .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i), .pmem_addr_i(pmem_addr_o),
    .pmem_re_i(pmem_re_o), .pmem_we_i(pmem_we_o), .pmem_wdata_i(pmem_wdata_o),
    .pmem_rdata_o(pmem_rdata_i), .pmem_done_o(pmem_done_i), .io_addr_i(io_addr_o),
    .io_we_i(io_we_o), .io_re_i(io_re_o), .io_wdata_i(io_wdata_o), .io_rdata_o(io_rdata_i));

  // Clock and strobe counters
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (!rst_i && sleep_req_o === 1'b1) sleep_cnt++;
    if (!rst_i && wdt_restart_o === 1'b1) wdt_cnt++;
  end

  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, e);
  endtask : wr
  task automatic chk_at(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, v, e);
    check(nm, v, exp);
  endtask : chk_at
  task automatic set_reg(input logic [4:0] i, input logic [7:0] d);
    wr(ADDR_REG_WINDOW, {15'h0, 1'b1, d, 3'h0, i});
  endtask : set_reg
  task automatic chk_reg(input string nm, input logic [4:0] i, input logic [7:0] exp);
    wr(ADDR_REG_WINDOW, {27'h0, i});
    chk_at(nm, ADDR_REG_DATA, {24'h0, exp});
  endtask : chk_reg
  // Issue a command, wait n-2 more cycles when n > 2, then read STATUS and check it is idle
  task automatic run(input op_t op, input logic [4:0] r, input logic [2:0] b,
                     input logic [18:0] lo, input int n);
    wr(ADDR_COMMAND, {op, r, b, lo});
    if (n > 2) repeat (n - 2) @(posedge core_clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0, v, e);
    check("busy at end", v[STAT_BUSY_BIT], 32'h0);
  endtask : run
  // Shift result and flags
  function automatic logic [15:0] shf(input op_t op, input logic [7:0] d, input logic [7:0] f);
    logic [7:0] r;
    logic c;
    case (op)
      op_logical_shift_up: {c, r} = {d, 1'b0};
      op_rotate_up_via_carry: {c, r} = {d, f[FLAG_C]};
      op_logical_shift_down: {r, c} = {1'b0, d};
      op_rotate_down_via_carry: {r, c} = {f[FLAG_C], d};
      default: {r, c} = {d[7], d};
    endcase
    f[FLAG_C] = c;
    f[FLAG_Z] = (r == 8'h00);
    f[FLAG_N] = r[7];
    f[FLAG_V] = r[7] ^ c;
    return {f, r};
  endfunction : shf

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    chk_at("flag word reset", ADDR_FLAG_WORD, 32'h0);
    chk_at("stack reset", ADDR_STACK_PTR, 32'h0);
    apb(1'b0, 8'h18, 32'h0, v, e);
    check("unmapped data", v, 32'h0);
    check("unmapped error", e, 32'h1);
    wr(ADDR_FLAG_WORD, 32'h6a);
    set_reg(5'd30, 8'h10);
    set_reg(5'd5, 8'ha5);
    // Transfers: stores, code loads, stack, I/O; then nibble swap
    run(op_offset_store, 5'd5, 3'd0, {6'd3, 13'h0}, 2);
    check("offset store", mdl.dmem[8'h13], 32'ha5);
    run(op_direct_store, 5'd5, 3'd0, 19'h0040, 2);
    check("direct store", mdl.dmem[8'h40], 32'ha5);
    run(op_code_space_load_r0, 5'd0, 3'd0, 19'h0, 3);
    chk_reg("load r0", 5'd0, 8'h2c);
    run(op_code_space_load, 5'd7, 3'd0, 19'h0, 3);
    chk_reg("load named", 5'd7, 8'h2c);
    run(op_code_space_load_inc, 5'd8, 3'd0, 19'h0, 3);
    chk_reg("load inc", 5'd8, 8'h2c);
    chk_reg("pointer inc", 5'd30, 8'h11);
    wr(ADDR_STACK_PTR, 32'h80);
    run(op_push, 5'd5, 3'd0, 19'h0, 2);
    check("push data", mdl.dmem[8'h80], 32'ha5);
    chk_at("push sp", ADDR_STACK_PTR, 32'h7f);
    run(op_pop, 5'd9, 3'd0, 19'h0, 2);
    chk_reg("pop data", 5'd9, 8'ha5);
    chk_at("pop sp", ADDR_STACK_PTR, 32'h80);
    run(op_io_bit_force_high, 5'd0, 3'd2, {6'd3, 13'h0}, 2);
    check("bit high", mdl.io[3], 32'h85);
    run(op_io_bit_force_low, 5'd0, 3'd0, {6'd3, 13'h0}, 2);
    check("bit low", mdl.io[3], 32'h84);
    run(op_port_out, 5'd5, 3'd0, {6'd4, 13'h0}, 1);
    check("port out", mdl.io[4], 32'ha5);
    run(op_port_in, 5'd10, 3'd0, {6'd3, 13'h0}, 1);
    chk_reg("port in", 5'd10, 8'h84);
    run(op_nibble_swap, 5'd5, 3'd0, 19'h0, 1);
    chk_reg("swap", 5'd5, 8'h5a);
    chk_at("flags kept", ADDR_FLAG_WORD, 32'h6a);
    // Shifts and rotates with both carry inputs
    for (int i = 0; i < 10; i++) begin
      sv = (i < 5) ? 8'h81 : 8'h01;
      fv = (i < 5) ? 8'h71 : 8'h70;
      set_reg(5'd11, sv);
      wr(ADDR_FLAG_WORD, {24'h0, fv});
      run(sh_ops[i % 5], 5'd11, 3'd0, 19'h0, 1);
      ex = shf(sh_ops[i % 5], sv, fv);
      chk_reg("shift value", 5'd11, ex[7:0]);
      chk_at("shift flags", ADDR_FLAG_WORD, {24'h0, ex[15:8]});
    end
    // Every flag set alone and cleared alone
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FLAG_WORD, 32'h0);
      run(op_flag_set, 5'd0, i[2:0], 19'h0, 1);
      chk_at("flag set", ADDR_FLAG_WORD, 32'h1 << i);
      wr(ADDR_FLAG_WORD, 32'hff);
      run(op_flag_clear, 5'd0, i[2:0], 19'h0, 1);
      chk_at("flag clear", ADDR_FLAG_WORD, 32'hff ^ (32'h1 << i));
    end
    // Transfer flag, sleep and watchdog
    wr(ADDR_FLAG_WORD, 32'h0);
    run(op_bit_to_transfer_flag, 5'd5, 3'd1, 19'h0, 1);
    chk_at("bit to flag", ADDR_FLAG_WORD, 32'h40);
    run(op_transfer_flag_to_bit, 5'd12, 3'd4, 19'h0, 1);
    chk_reg("flag to bit", 5'd12, 8'h10);
    run(op_sleep, 5'd0, 3'd0, 19'h0, 1);
    run(op_watchdog_restart, 5'd0, 3'd0, 19'h0, 1);
    run(op_nop, 5'd0, 3'd0, 19'h0, 1);
    check("sleep pulses", sleep_cnt, 32'h1);
    check("restart pulses", wdt_cnt, 32'h1);
    chk_at("flags after", ADDR_FLAG_WORD, 32'h40);
    // Code word write, slow completion, refusal meanwhile
    set_reg(5'd0, 8'h34);
    set_reg(5'd1, 8'h12);
    wr(ADDR_COMMAND, {op_code_space_write, 27'h0});
    apb(1'b1, ADDR_COMMAND, 32'h0, v, e);
    check("busy refusal", e, 32'h1);
    for (int n = 0; n <= 20; n++) begin
      if (n == 20) begin
        bad_count++;
        end_of_test();
      end
      apb(1'b0, ADDR_STATUS, 32'h0, v, e);
      if (v[STAT_BUSY_BIT] === 1'b0) break;
    end
    check("code word", mdl.pw_word, 32'h1234);
    check("code addr", mdl.pw_addr, 32'h0011);
    end_of_test();
  end
endmodule : tb_bit_and_transfer_exec
